// ==== common/probe_latch_pkg.sv ====
package probe_latch_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths of the bus and of the captured values
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned POS_W  = 32;
  localparam int unsigned CNT_W  = 32;
  localparam int unsigned CH_N   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CONTROL    = 16'h60b8;
  localparam logic [ADDR_W-1:0] IDX_STATUS     = 16'h60b9;
  localparam logic [ADDR_W-1:0] IDX_ONE_RISE_P = 16'h60ba;
  localparam logic [ADDR_W-1:0] IDX_ONE_FALL_P = 16'h60bb;
  localparam logic [ADDR_W-1:0] IDX_TWO_RISE_P = 16'h60bc;
  localparam logic [ADDR_W-1:0] IDX_TWO_FALL_P = 16'h60bd;
  localparam logic [ADDR_W-1:0] IDX_ONE_RISE_C = 16'h60d5;
  localparam logic [ADDR_W-1:0] IDX_ONE_FALL_C = 16'h60d6;
  localparam logic [ADDR_W-1:0] IDX_TWO_RISE_C = 16'h60d7;
  localparam logic [ADDR_W-1:0] IDX_TWO_FALL_C = 16'h60d8;
  localparam logic [ADDR_W-1:0] IDX_POLARITY   = 16'h2007;
  localparam logic [ADDR_W-1:0] IDX_DIN_STATUS = 16'h60fd;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, per channel byte of control and status, and probe level bits of input status
  localparam int unsigned CH_STRIDE = 8;
  localparam int unsigned CTL_EN    = 0;
  localparam int unsigned CTL_MODE  = 1;
  localparam int unsigned CTL_SRC   = 2;
  localparam int unsigned CTL_RISE  = 4;
  localparam int unsigned CTL_FALL  = 5;
  localparam int unsigned ST_EN     = 0;
  localparam int unsigned ST_RISE   = 1;
  localparam int unsigned ST_FALL   = 2;
  localparam int unsigned DIN_FIRST = 26;
  localparam int unsigned DIN_SECOND = 27;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and writable masks
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] CONTROL_MASK   = 16'h3737;
  localparam logic [1:0]  POLARITY_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_type;

endpackage : probe_latch_pkg

// ==== common/reg_access_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Committed register accesses from the bus front end to the register file
interface reg_access_if;
  import probe_latch_pkg::*;
  logic [ADDR_W-1:0] addr;   // Word index of the access
  logic [DATA_W-1:0] wdata;  // Write data
  logic [3:0]        be;     // Byte enables
  logic              wr;     // One-cycle write commit
  logic [DATA_W-1:0] rdata;  // Read value of addr

  modport front (output addr, wdata, be, wr, input rdata);
  modport regs  (input addr, wdata, be, wr, output rdata);
endinterface : reg_access_if

`default_nettype wire

// ==== verilog/level_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clock_i,  // System clock
  input  wire logic         rst_i,    // Synchronous reset
  input  wire logic [W-1:0] d_i,      // Asynchronous levels
  output logic      [W-1:0] q_o       // Synchronised levels
);

  logic [W-1:0] meta;

  // Two flops, the first read only by the second
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : level_sync

`default_nettype wire

// ==== verilog/avalon_front.sv ====
`timescale 1ns/1ps
`default_nettype none

module avalon_front (
  input  wire logic                           clock_i,       // System clock
  input  wire logic                           rst_i,         // Synchronous reset
  input  wire logic [probe_latch_pkg::ADDR_W-1:0] address_i, // Word address
  input  wire logic                           read_i,        // Read request
  input  wire logic                           write_i,       // Write request
  input  wire logic [probe_latch_pkg::DATA_W-1:0] writedata_i, // Write data
  input  wire logic [3:0]                     byteenable_i,  // Byte enables
  output logic      [probe_latch_pkg::DATA_W-1:0] readdata_o,  // Read data
  output logic                                waitrequest_o, // Stall
  reg_access_if.front                         rif            // Register side
);
  import probe_latch_pkg::*;

  bus_state_type state;
  bus_state_type next_state;
  wire           req;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode and commit strobe
  assign req        = read_i | write_i;
  assign next_state = (state == BUS_IDLE && req) ? BUS_ACK : BUS_IDLE;
  assign rif.addr   = address_i;
  assign rif.wdata  = writedata_i;
  assign rif.be     = byteenable_i;
  assign rif.wr     = write_i & (state == BUS_ACK);

  // One wait cycle, then a one-cycle acknowledge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state         <= BUS_IDLE;
      waitrequest_o <= 1'b1;
      readdata_o    <= '0;
    end else begin
      state         <= next_state;
      waitrequest_o <= (next_state != BUS_ACK);
      if (state == BUS_IDLE && read_i) begin
        readdata_o <= rif.rdata;
      end
    end
  end

endmodule : avalon_front

`default_nettype wire

// ==== verilog/probe_position_latch.sv ====
// Contract
// R1: Control bit 0 enables channel one, clearing it disables it.
// R2: Bits 1 and 9 pick single-shot (0) or continuous (1) capture.
// R3: Bit 2 picks channel one source: first probe input or index pulse.
// R4: Bit 4 allows rising-edge capture on channel one, else suppressed.
// R5: Bit 5 allows falling-edge capture on channel one, else suppressed.
// R6: Bits 8 to 13 configure channel two the same way.
// R7: Status bits 0 and 8 mirror enables; bit 1 shows rise capture done.
// R8: Status bit 2 shows channel one falling capture done.
// R9: Status bits 9 and 10 show channel two rise and fall captures done.
// R10: Accepted rising event of channel one stores its position.
// R11: Accepted falling event of channel one stores its position.
// R12: Channel two keeps separate rise and fall position registers.
// R13: Each channel counts rise and fall captures separately, readable.
// R14: Single-shot captures only the first trigger until re-armed.
// R15: Software re-arms single-shot by clearing then setting enable.
// R16: Continuous mode captures every trigger, holding until overwritten.
// R17: Continuous mode stays armed with no enable toggle.
// R18: Polarity bits 0 and 1 invert the two probe inputs.
// R19: Changing enable, source or edges clears counters and status flags.
// R20: Probe input levels show in bits 26 and 27 of input status.
// R21: Positions signed 32-bit, counters unsigned 32-bit, all reset zero.
// R22: A capture bumps its counter and sets its flag with the position.
// R23: Inputs synchronised first; position sampled at the detected edge.
`timescale 1ns/1ps
`default_nettype none

module probe_position_latch (
  input  wire logic                               clock_i,       // 10 MHz clock
  input  wire logic                               rst_i,         // Sync reset
  input  wire logic [probe_latch_pkg::ADDR_W-1:0] address_i,     // Word address
  input  wire logic                               read_i,        // Bus read
  input  wire logic                               write_i,       // Bus write
  input  wire logic [probe_latch_pkg::DATA_W-1:0] writedata_i,   // Write data
  input  wire logic [3:0]                         byteenable_i,  // Byte lanes
  output logic      [probe_latch_pkg::DATA_W-1:0] readdata_o,    // Read data
  output logic                                    waitrequest_o, // Bus stall
  input  wire logic                               probe_input_first_i,  // Pin
  input  wire logic                               probe_input_second_i, // Pin
  input  wire logic                               index_pulse_i, // Encoder index
  input  wire logic [probe_latch_pkg::POS_W-1:0]  position_i     // Feedback
);
  import probe_latch_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  reg_access_if rif ();

  avalon_front u_front (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .address_i     (address_i),
    .read_i        (read_i),
    .write_i       (write_i),
    .writedata_i   (writedata_i),
    .byteenable_i  (byteenable_i),
    .readdata_o    (readdata_o),
    .waitrequest_o (waitrequest_o),
    .rif           (rif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire hit_control;
  wire hit_status;
  wire hit_one_rise_p;
  wire hit_one_fall_p;
  wire hit_two_rise_p;
  wire hit_two_fall_p;
  wire hit_one_rise_c;
  wire hit_one_fall_c;
  wire hit_two_rise_c;
  wire hit_two_fall_c;
  wire hit_polarity;
  wire hit_din_status;

  // Word index match, shared by the write and read paths
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] idx);
    return addr == idx;
  endfunction : addr_is

  // One hit per register index
  assign hit_control    = addr_is(rif.addr, IDX_CONTROL);
  assign hit_status     = addr_is(rif.addr, IDX_STATUS);
  assign hit_one_rise_p = addr_is(rif.addr, IDX_ONE_RISE_P);
  assign hit_one_fall_p = addr_is(rif.addr, IDX_ONE_FALL_P);
  assign hit_two_rise_p = addr_is(rif.addr, IDX_TWO_RISE_P);
  assign hit_two_fall_p = addr_is(rif.addr, IDX_TWO_FALL_P);
  assign hit_one_rise_c = addr_is(rif.addr, IDX_ONE_RISE_C);
  assign hit_one_fall_c = addr_is(rif.addr, IDX_ONE_FALL_C);
  assign hit_two_rise_c = addr_is(rif.addr, IDX_TWO_RISE_C);
  assign hit_two_fall_c = addr_is(rif.addr, IDX_TWO_FALL_C);
  assign hit_polarity   = addr_is(rif.addr, IDX_POLARITY);
  assign hit_din_status = addr_is(rif.addr, IDX_DIN_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [2:0] pin_sync;
  wire  [1:0] ext_level;
  wire        index_level;

  level_sync #(.W(3)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     ({index_pulse_i, probe_input_second_i, probe_input_first_i}),
    .q_o     (pin_sync)
  );  // see R23

  // Synchronised physical levels
  assign ext_level   = pin_sync[1:0];
  assign index_level = pin_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [15:0] control;
  logic [1:0]  polarity;

  wire sel_control;
  wire sel_polarity;

  // Write decode
  assign sel_control  = rif.wr && hit_control;
  assign sel_polarity = rif.wr && hit_polarity;

  // Control word, low two byte lanes, reserved bits kept zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      control <= CONTROL_RESET;
    end else if (sel_control) begin
      if (rif.be[0]) begin
        control[7:0] <= rif.wdata[7:0] & CONTROL_MASK[7:0];  // see R1
      end
      if (rif.be[1]) begin
        control[15:8] <= rif.wdata[15:8] & CONTROL_MASK[15:8];  // see R6
      end
    end
  end

  // Probe polarity, lane zero only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      polarity <= POLARITY_RESET;
    end else if (sel_polarity && rif.be[0]) begin
      polarity <= rif.wdata[1:0];  // see R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture channels

  logic        [CNT_W-1:0] rise_count [CH_N];
  logic        [CNT_W-1:0] fall_count [CH_N];
  logic signed [POS_W-1:0] rise_pos   [CH_N];
  logic signed [POS_W-1:0] fall_pos   [CH_N];
  logic        [CH_N-1:0]  rise_done;
  logic        [CH_N-1:0]  fall_done;
  wire         [CH_N-1:0]  ch_enable;

  genvar c;
  generate
    for (c = 0; c < CH_N; c++) begin : g_ch
      wire [7:0] cfg;
      wire       enable;
      wire       continuous;
      wire       use_index;
      wire       rise_allow;
      wire       fall_allow;
      wire [3:0] watched;
      wire       cfg_change;
      wire       level;
      wire       rise_edge;
      wire       fall_edge;
      wire       rise_take;
      wire       fall_take;
      logic      prev_level;
      logic      prev_index;
      logic [3:0] watched_q;

      // Channel fields of the control word
      assign cfg        = control[c*CH_STRIDE +: 8];
      assign enable     = cfg[CTL_EN];     // see R1
      assign continuous = cfg[CTL_MODE];   // see R2
      assign use_index  = cfg[CTL_SRC];    // see R3
      assign rise_allow = cfg[CTL_RISE];   // see R4
      assign fall_allow = cfg[CTL_FALL];   // see R5
      assign ch_enable[c] = enable;

      // Settings whose change restarts the channel
      assign watched    = {fall_allow, rise_allow, use_index, enable};
      assign cfg_change = (watched != watched_q);  // see R19

      // Source select after optional inversion of the probe pin
      assign level = use_index ? index_level
                               : (ext_level[c] ^ polarity[c]);  // see R18

      // Edges, none in the cycle the source is switched
      assign rise_edge = level & ~prev_level & (use_index == prev_index);
      assign fall_edge = ~level & prev_level & (use_index == prev_index);

      // Accepted events; single-shot waits for its flag to clear
      assign rise_take = enable & rise_allow & rise_edge
                       & (continuous | ~rise_done[c] | cfg_change);  // see R14
      assign fall_take = enable & fall_allow & fall_edge
                       & (continuous | ~fall_done[c] | cfg_change);  // see R16 R17

      // Edge detector history and watched settings
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          prev_level <= 1'b0;
          prev_index <= 1'b0;
          watched_q  <= 4'h0;
        end else begin
          prev_level <= level;
          prev_index <= use_index;
          watched_q  <= watched;
        end
      end

      // Latched positions, held until the next accepted edge
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          rise_pos[c] <= '0;
          fall_pos[c] <= '0;  // see R21
        end else begin
          if (rise_take) begin
            rise_pos[c] <= position_i;  // see R10
          end
          if (fall_take) begin
            fall_pos[c] <= position_i;  // see R11
          end
        end
      end

      // Counters and executed flags; a capture wins over the restart
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          rise_count[c] <= '0;
          fall_count[c] <= '0;
          rise_done[c]  <= 1'b0;
          fall_done[c]  <= 1'b0;
        end else begin
          rise_done[c] <= (rise_done[c] & ~cfg_change) | rise_take;  // see R22
          fall_done[c] <= (fall_done[c] & ~cfg_change) | fall_take;  // see R22
          if (cfg_change) begin
            rise_count[c] <= CNT_W'(rise_take);  // see R19
            fall_count[c] <= CNT_W'(fall_take);  // see R19
          end else begin
            rise_count[c] <= rise_count[c] + CNT_W'(rise_take);  // see R13
            fall_count[c] <= fall_count[c] + CNT_W'(fall_take);  // see R13
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Readable state

  wire [15:0]       status;
  wire [DATA_W-1:0] din_status;

  // Status word per channel byte
  assign status = {5'h0, fall_done[1], rise_done[1], ch_enable[1],    // see R9
                   5'h0, fall_done[0], rise_done[0], ch_enable[0]};   // see R7

  // Probe levels as seen at the pins
  assign din_status = {4'h0, ext_level[1], ext_level[0], 26'h0};  // see R20

  // Read decode, unmapped indices read zero
  assign rif.rdata =
    hit_control    ? {16'h0, control}     :
    hit_status     ? {16'h0, status}      :  // see R8
    hit_one_rise_p ? DATA_W'(rise_pos[0]) :
    hit_one_fall_p ? DATA_W'(fall_pos[0]) :
    hit_two_rise_p ? DATA_W'(rise_pos[1]) :  // see R12
    hit_two_fall_p ? DATA_W'(fall_pos[1]) :  // see R12
    hit_one_rise_c ? rise_count[0]        :
    hit_one_fall_c ? fall_count[0]        :
    hit_two_rise_c ? rise_count[1]        :
    hit_two_fall_c ? fall_count[1]        :
    hit_polarity   ? {30'h0, polarity}    :
    hit_din_status ? din_status           :
                     {DATA_W{1'b0}};

endmodule : probe_position_latch

`default_nettype wire

// ==== bench/probe_position_latch_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module probe_position_latch_checker (
  input wire logic                               clock_i,       // Clock
  input wire logic                               rst_i,         // Reset
  input wire logic [probe_latch_pkg::ADDR_W-1:0] address_i,     // Address
  input wire logic                               read_i,        // Read
  input wire logic                               write_i,       // Write
  input wire logic [probe_latch_pkg::DATA_W-1:0] writedata_i,   // Write data
  input wire logic [3:0]                         byteenable_i,  // Lanes
  input wire logic [probe_latch_pkg::DATA_W-1:0] readdata_o,    // Read data
  input wire logic                               waitrequest_o, // Stall
  input wire logic                               probe_input_first_i,  // Pin
  input wire logic                               probe_input_second_i, // Pin
  input wire logic                               index_pulse_i, // Index
  input wire logic [probe_latch_pkg::POS_W-1:0]  position_i     // Position
);
  import probe_latch_pkg::*;

  // Read acknowledge and address decode
  wire logic ack_rd;
  wire logic mapped;
  assign ack_rd = read_i && !waitrequest_o;
  assign mapped = (address_i >= IDX_CONTROL && address_i <= IDX_TWO_FALL_P) ||
                  (address_i >= IDX_ONE_RISE_C && address_i <= IDX_TWO_FALL_C) ||
                  address_i == IDX_POLARITY || address_i == IDX_DIN_STATUS;

  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer and read data
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=> waitrequest_o && readdata_o == '0)
    else $error("bus not idle after reset");
  a_ack_one: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("acknowledge longer than one cycle");
  a_wait_then_ack: assert property ($rose(read_i || write_i) |-> waitrequest_o ##1 !waitrequest_o)
    else $error("request not answered after one wait cycle");
  a_ack_caused: assert property (!waitrequest_o |-> $past(read_i || write_i))
    else $error("acknowledge without request");
  a_data_hold: assert property (!$past(read_i) |-> $stable(readdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (ack_rd && !mapped |-> readdata_o == '0)
    else $error("unmapped read not zero");
  a_ctl_reserved: assert property (ack_rd && address_i == IDX_CONTROL |-> (readdata_o & ~32'h0000_3737) == '0)
    else $error("control reserved bits set");
  a_st_reserved: assert property (ack_rd && address_i == IDX_STATUS |-> (readdata_o & ~32'h0000_0707) == '0)
    else $error("status reserved bits set");
endmodule : probe_position_latch_checker

`default_nettype wire

// ==== bench/probe_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module probe_sensor_model (
  input  wire logic                              clock_i,              // Clock
  output logic                                   probe_input_first_o,  // Pin
  output logic                                   probe_input_second_o, // Pin
  output logic                                   index_pulse_o,        // Index
  output logic [probe_latch_pkg::POS_W-1:0]      position_o            // Position
);
  logic [2:0]  pins = 3'h0;
  logic [31:0] pos  = 32'h0000_0000;

  // Pin levels and feedback position
  assign probe_input_first_o  = pins[0];
  assign probe_input_second_o = pins[1];
  assign index_pulse_o        = pins[2];
  assign position_o           = pos;

  // Flip one pin with a fresh position, then hold both long enough
  task automatic toggle(input int p, input logic [31:0] v);
    @(posedge clock_i);
    pos     <= v;
    pins[p] <= ~pins[p];
    repeat (6) @(posedge clock_i); // Past sync and capture
  endtask : toggle
endmodule : probe_sensor_model

`default_nettype wire

// ==== bench/probe_position_latch_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module probe_position_latch_test;
  import probe_latch_pkg::*;
  logic              clock_i, rst_i, read_i, write_i, waitrequest_o;
  logic              pin_a, pin_b, index_pulse;
  logic [ADDR_W-1:0] address_i;
  logic [DATA_W-1:0] writedata_i, readdata_o, q, last_pos;
  logic [POS_W-1:0]  position;
  logic [3:0]        byteenable_i;
  logic [15:0]       ctl;
  logic [1:0]        pol;
  logic [2:0]        raw;
  logic [31:0]       m_pos[4], m_cnt[4];
  logic              m_flag[4];
  int                miscompares, checked, seed, i, j;

  probe_position_latch u_probe_position_latch (
    .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .probe_input_first_i(pin_a), .probe_input_second_i(pin_b),
    .index_pulse_i(index_pulse), .position_i(position));

  probe_sensor_model u_probe_sensor_model (
    .clock_i(clock_i), .probe_input_first_o(pin_a), .probe_input_second_o(pin_b),
    .index_pulse_o(index_pulse), .position_o(position));

  // Clock source
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus cycle
  task automatic end_sim;
    $display("Checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    read_i      <= !wr;
    write_i     <= wr;
    address_i   <= a;
    writedata_i <= d;
    do begin
      @(posedge clock_i);
    end while (waitrequest_o !== 1'b0); // A hang is ended by the watchdog
    q = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
    @(posedge clock_i); // One idle edge between requests
  endtask : bus

  ////////////////////////////////////////////////////////////////////////////
  // Reference model of both channels
  task automatic edge_seen(input int p, input logic [31:0] v);
    logic lvl;
    int   k;
    lvl = raw[p] ^ (p < 2 ? pol[p] : 1'b0);
    for (int c = 0; c < 2; c++) begin
      k = 2 * c + (lvl ? 0 : 1);
      if ((ctl[8*c+2] ? p == 2 : p == c) && ctl[8*c] && ctl[8*c+4+k%2] && (ctl[8*c+1] || !m_flag[k])) begin
        m_pos[k] = v;
        m_cnt[k]++;
        m_flag[k] = 1'b1;
      end
    end
  endtask : edge_seen

  task automatic wr_ctl(input logic [15:0] v);
    for (int c = 0; c < 2; c++) begin
      if ((((ctl ^ v) >> (8 * c)) & 16'h0035) != 16'h0000) begin
        m_cnt[2*c]    = 0;
        m_cnt[2*c+1]  = 0;
        m_flag[2*c]   = 1'b0;
        m_flag[2*c+1] = 1'b0;
      end
    end
    ctl = v & CONTROL_MASK;
    bus(1'b1, IDX_CONTROL, {16'h0000, v});
  endtask : wr_ctl

  task automatic wr_pol(input logic [1:0] v);
    logic [1:0] old;
    old = pol;
    pol = v;
    bus(1'b1, IDX_POLARITY, {30'h0, v});
    for (int p = 0; p < 2; p++) begin
      if (old[p] != v[p]) edge_seen(p, last_pos);
    end
    repeat (6) @(posedge clock_i);
  endtask : wr_pol

  task automatic flip(input int p);
    last_pos = $random(seed);
    raw[p]   = ~raw[p];
    edge_seen(p, last_pos);
    u_probe_sensor_model.toggle(p, last_pos);
  endtask : flip

  task automatic check_all;
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(q, {21'h0, m_flag[3], m_flag[2], ctl[8], 5'h0, m_flag[1], m_flag[0], ctl[0]});
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, IDX_ONE_RISE_P + 16'(k), 32'h0);
      chk(q, m_pos[k]);
      bus(1'b0, IDX_ONE_RISE_C + 16'(k), 32'h0);
      chk(q, m_cnt[k]);
    end
    bus(1'b0, IDX_DIN_STATUS, 32'h0);
    chk(q & 32'h0c00_0000, {4'h0, raw[1], raw[0], 26'h0});
  endtask : check_all

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 73241;
    {read_i, write_i, address_i, writedata_i, byteenable_i} = {2'b00, 16'h0, 32'h0, 4'hf};
    {ctl, pol, raw, last_pos, miscompares, checked} = '0;
    for (int k = 0; k < 4; k++) begin
      {m_pos[k], m_cnt[k], m_flag[k]} = '0;
    end
    rst_i = 1'b1;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    check_all;
    bus(1'b0, 16'h1234, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, IDX_ONE_RISE_C, 32'hffff_ffff);
    wr_ctl(16'hffff);
    bus(1'b0, IDX_CONTROL, 32'h0);
    chk(q, 32'h0000_3737);
    // Upper lane only: channel one settings must survive
    byteenable_i <= 4'h2;
    bus(1'b1, IDX_CONTROL, 32'h0);
    byteenable_i <= 4'hf;
    bus(1'b0, IDX_CONTROL, 32'h0);
    chk(q, 32'h0000_0037);
    ctl = 16'h0037;
    wr_ctl(16'h0031);
    repeat (4) flip(0);
    check_all;
    wr_ctl(16'h0030);
    wr_ctl(16'h0031);
    flip(0);
    flip(0);
    check_all;
    wr_ctl(16'h3737);
    repeat (5) flip(2);
    check_all;
    // Random configurations, polarities and pin edges
    for (i = 0; i < 48; i++) begin
      if (i % 8 == 0) wr_pol(2'($random(seed)));
      if (i % 4 == 0) wr_ctl(16'($random(seed)));
      j = $random(seed);
      flip((j & 32'h7fff_ffff) % 3);
      if (i % 4 == 3) check_all;
    end
    end_sim;
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge clock_i);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
endmodule : probe_position_latch_test

bind probe_position_latch probe_position_latch_checker u_probe_position_latch_checker (
  .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .probe_input_first_i(probe_input_first_i), .probe_input_second_i(probe_input_second_i),
  .index_pulse_i(index_pulse_i), .position_i(position_i));

`default_nettype wire
